// *** hw/ifw_identify_feature_words.sv ***
// Purpose: Builds the six identify feature words and holds their live enable state
// Assumes: Command decode and identify transfer sit outside and share CLK_IN
// Notes:   The SMART enable is reloaded from nonvolatile storage at every reset
//
// Overview of operation
// - Supported words two and three drive bit 14 high and bit 15 low.
// - Supported word one always sets bits 3, 12, 13 and 14.
// - Supported word one always clears bits 2, 4, 7, 8, 9, 10.
// - Supported word one bits 0, 1, 5, 6 follow build options.
// - Supported word two always sets bits 2, 10, 12 and 13.
// - Supported word two clears bits 0, 1, 4 to 9 and 11.
// - Supported word two bit 3 follows the power management build option.
// - Supported word three bits 5, 6 show logging and FUA write support.
// - Supported word three clears bits 0-4, 7-10, 13; 11, 12 reserved zero.
// - Enabled word three drives bit 14 high and bit 15 low.
// - Enabled word one bit 0 shows SMART enable, kept across power cycles.
// - Enabled word one bit 1 rises once a security password is set.
// - Enabled word one bits 5, 6 follow write cache and look-ahead enables.
// - Enabled word one fixed bits match the supported word one.
// - Enabled word two bit 3 rises once power management is enabled.
// - Enabled word two sets bits 2, 10, 12, 13 and 15.
// - Enabled word two clears bits 0, 1, 4-6, 8, 9, 11; reserved zero.
// - Enabled word three mirrors bits 5, 6; other low bits zero.
// - The words are returned within the identify parameter block.
`timescale 1ns/1ps

module ifw_identify_feature_words
  import ifw_pkg::*;
#(
  parameter bit SMART_SUPPORTED = 1'b1,
  parameter bit SECURITY_SUPPORTED = 1'b1,
  parameter bit WCACHE_SUPPORTED = 1'b1,
  parameter bit LOOKAHEAD_SUPPORTED = 1'b1,
  parameter bit APM_SUPPORTED = 1'b1,
  parameter bit GPL_SUPPORTED = 1'b1,
  parameter bit FUA_SUPPORTED = 1'b1,
  parameter bit WCACHE_RESET_ON = 1'b1,
  parameter bit LOOKAHEAD_RESET_ON = 1'b1
) (
  input wire logic CLK_IN,            // Controller clock
  input wire logic RESET_N_IN,        // Synchronous reset, active low
  input wire logic IDENT_RD_IN,       // Read strobe from identify transfer
  input wire logic [7:0] IDENT_IDX_IN, // Identify word index
  output logic [15:0] IDENT_DATA_OUT, // Word read back
  output logic IDENT_VALID_OUT,       // Read data valid pulse
  output logic IDENT_HIT_OUT,         // Index addressed this block
  input wire ifw_cmd_t CMD_IN,        // Feature command code
  input wire logic CMD_VALID_IN,      // Feature command strobe
  output logic CMD_DONE_OUT,          // Command accepted pulse
  output logic CMD_ABORT_OUT,         // Command refused pulse
  input wire logic SMART_NV_IN,       // Stored SMART enable
  output logic SMART_NV_OUT           // SMART enable to store
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic is_feature_word(input logic [7:0] idx);
    is_feature_word = (idx >= IFW_IDX_SUPPORTED_1) && (idx <= IFW_IDX_ENABLED_3);
  endfunction

  // Refused codes: the empty code, unknown codes and switching on a left-out feature
  function automatic logic cmd_refused(input ifw_cmd_t cmd);
    case (cmd)
      IFW_CMD_SMART_ON: begin
        cmd_refused = !SMART_SUPPORTED;
      end
      IFW_CMD_PASSWORD_SET: begin
        cmd_refused = !SECURITY_SUPPORTED;
      end
      IFW_CMD_WCACHE_ON: begin
        cmd_refused = !WCACHE_SUPPORTED;
      end
      IFW_CMD_LOOKAHEAD_ON: begin
        cmd_refused = !LOOKAHEAD_SUPPORTED;
      end
      IFW_CMD_APM_ON: begin
        cmd_refused = !APM_SUPPORTED;
      end
      IFW_CMD_SMART_OFF, IFW_CMD_PASSWORD_CLEAR, IFW_CMD_WCACHE_OFF, IFW_CMD_LOOKAHEAD_OFF, IFW_CMD_APM_OFF: begin
        cmd_refused = 1'b0;
      end
      default: begin
        cmd_refused = 1'b1;
      end
    endcase
  endfunction

  ifw_state_t state_reg;
  ifw_state_t state_next;
  logic [15:0] sup1;
  logic [15:0] sup2;
  logic [15:0] sup3;
  logic [15:0] en1;
  logic [15:0] en2;
  logic [15:0] en3;
  logic [15:0] word_sel;

  // ***************************************************************
  // Word assembly
  // ***************************************************************
  always_comb begin
    sup1 = IFW_FIXED_WORD1;
    sup1[IFW_BIT_SMART] = SMART_SUPPORTED;
    sup1[IFW_BIT_SECURITY] = SECURITY_SUPPORTED;
    sup1[IFW_BIT_WCACHE] = WCACHE_SUPPORTED;
    sup1[IFW_BIT_LOOKAHEAD] = LOOKAHEAD_SUPPORTED;
    sup2 = IFW_FIXED_SUP2;
    sup2[IFW_BIT_APM] = APM_SUPPORTED;
    sup3 = IFW_FIXED_WORD3;
    sup3[IFW_BIT_GPL] = GPL_SUPPORTED;
    sup3[IFW_BIT_FUA] = FUA_SUPPORTED;
    en1 = IFW_FIXED_WORD1;
    en1[IFW_BIT_SMART] = state_reg.smart_en;
    en1[IFW_BIT_SECURITY] = state_reg.security_en;
    en1[IFW_BIT_WCACHE] = state_reg.wcache_en;
    en1[IFW_BIT_LOOKAHEAD] = state_reg.lookahead_en;
    en2 = IFW_FIXED_EN2;
    en2[IFW_BIT_APM] = state_reg.apm_en;
    en3 = IFW_FIXED_WORD3;
    en3[IFW_BIT_GPL] = GPL_SUPPORTED;
    en3[IFW_BIT_FUA] = FUA_SUPPORTED;
  end

  // Words outside this block read as zero so the outer mux can OR them
  always_comb begin
    if (IDENT_IDX_IN == IFW_IDX_SUPPORTED_1) begin
      word_sel = sup1;
    end else if (IDENT_IDX_IN == IFW_IDX_SUPPORTED_2) begin
      word_sel = sup2;
    end else if (IDENT_IDX_IN == IFW_IDX_SUPPORTED_3) begin
      word_sel = sup3;
    end else if (IDENT_IDX_IN == IFW_IDX_ENABLED_1) begin
      word_sel = en1;
    end else if (IDENT_IDX_IN == IFW_IDX_ENABLED_2) begin
      word_sel = en2;
    end else if (IDENT_IDX_IN == IFW_IDX_ENABLED_3) begin
      word_sel = en3;
    end else begin
      word_sel = IFW_RST_DATA;
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.rd_valid = IDENT_RD_IN;
    state_next.cmd_done = 1'b0;
    state_next.cmd_abort = 1'b0;
    if (IDENT_RD_IN) begin
      state_next.rd_data = word_sel;
    end
    // Enables move only on feature commands; switching on an unsupported feature is refused
    if (CMD_VALID_IN) begin
      state_next.cmd_done = 1'b1;
      case (CMD_IN)
        IFW_CMD_SMART_ON: begin
          if (SMART_SUPPORTED) begin
            state_next.smart_en = 1'b1;
          end
        end
        IFW_CMD_SMART_OFF: begin
          state_next.smart_en = 1'b0;
        end
        IFW_CMD_PASSWORD_SET: begin
          if (SECURITY_SUPPORTED) begin
            state_next.security_en = 1'b1;
          end
        end
        IFW_CMD_PASSWORD_CLEAR: begin
          state_next.security_en = 1'b0;
        end
        IFW_CMD_WCACHE_ON: begin
          if (WCACHE_SUPPORTED) begin
            state_next.wcache_en = 1'b1;
          end
        end
        IFW_CMD_WCACHE_OFF: begin
          state_next.wcache_en = 1'b0;
        end
        IFW_CMD_LOOKAHEAD_ON: begin
          if (LOOKAHEAD_SUPPORTED) begin
            state_next.lookahead_en = 1'b1;
          end
        end
        IFW_CMD_LOOKAHEAD_OFF: begin
          state_next.lookahead_en = 1'b0;
        end
        IFW_CMD_APM_ON: begin
          if (APM_SUPPORTED) begin
            state_next.apm_en = 1'b1;
          end
        end
        IFW_CMD_APM_OFF: begin
          state_next.apm_en = 1'b0;
        end
        default: begin
          state_next.cmd_done = 1'b0;
        end
      endcase
      if (cmd_refused(CMD_IN)) begin
        state_next.cmd_done = 1'b0;
        state_next.cmd_abort = 1'b1;
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // SMART enable is reloaded from the store at reset, so it survives power cycles
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      state_reg.smart_en <= SMART_NV_IN & SMART_SUPPORTED;
      state_reg.security_en <= IFW_RST_SECURITY;
      state_reg.wcache_en <= WCACHE_RESET_ON & WCACHE_SUPPORTED;
      state_reg.lookahead_en <= LOOKAHEAD_RESET_ON & LOOKAHEAD_SUPPORTED;
      state_reg.apm_en <= IFW_RST_APM;
      state_reg.rd_data <= IFW_RST_DATA;
      state_reg.rd_valid <= 1'b0;
      state_reg.cmd_done <= 1'b0;
      state_reg.cmd_abort <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign IDENT_DATA_OUT = state_reg.rd_data;
  assign IDENT_VALID_OUT = state_reg.rd_valid;
  assign IDENT_HIT_OUT = is_feature_word(IDENT_IDX_IN);
  assign CMD_DONE_OUT = state_reg.cmd_done;
  assign CMD_ABORT_OUT = state_reg.cmd_abort;
  assign SMART_NV_OUT = state_reg.smart_en;

endmodule

// *** hw/ifw_pkg.sv ***
// Purpose: Constants and types shared by the identify feature word generator
// Assumes: Identify words are addressed by their 8-bit word index
// Notes:   All word layouts are 16 bits wide
package ifw_pkg;

  // ***************************************************************
  // Word indices inside the identify parameter block
  // ***************************************************************
  localparam logic [7:0] IFW_IDX_SUPPORTED_1 = 8'h52;
  localparam logic [7:0] IFW_IDX_SUPPORTED_2 = 8'h53;
  localparam logic [7:0] IFW_IDX_SUPPORTED_3 = 8'h54;
  localparam logic [7:0] IFW_IDX_ENABLED_1 = 8'h55;
  localparam logic [7:0] IFW_IDX_ENABLED_2 = 8'h56;
  localparam logic [7:0] IFW_IDX_ENABLED_3 = 8'h57;

  // ***************************************************************
  // Bit positions of live and optional fields
  // ***************************************************************
  localparam int IFW_BIT_SMART = 0;
  localparam int IFW_BIT_SECURITY = 1;
  localparam int IFW_BIT_WCACHE = 5;
  localparam int IFW_BIT_LOOKAHEAD = 6;
  localparam int IFW_BIT_APM = 3;
  localparam int IFW_BIT_GPL = 5;
  localparam int IFW_BIT_FUA = 6;

  // ***************************************************************
  // Fixed bit patterns (ones forced, every other fixed bit zero)
  // ***************************************************************
  // Word one: bits 3, 12, 13, 14 set
  localparam logic [15:0] IFW_FIXED_WORD1 = 16'h7008;
  // Supported word two: bits 2, 10, 12, 13, 14 set, bit 15 clear
  localparam logic [15:0] IFW_FIXED_SUP2 = 16'h7404;
  // Word three: bit 14 set, bit 15 clear
  localparam logic [15:0] IFW_FIXED_WORD3 = 16'h4000;
  // Enabled word two: bits 2, 10, 12, 13, 15 set
  localparam logic [15:0] IFW_FIXED_EN2 = 16'hb404;

  // ***************************************************************
  // Values after reset
  // ***************************************************************
  localparam logic [15:0] IFW_RST_DATA = 16'h0000;
  localparam logic IFW_RST_SECURITY = 1'b0;
  localparam logic IFW_RST_APM = 1'b0;

  // ***************************************************************
  // Feature commands decoded elsewhere and handed to this block
  // ***************************************************************
  typedef enum logic [3:0] {
    IFW_CMD_NONE,
    IFW_CMD_SMART_ON,
    IFW_CMD_SMART_OFF,
    IFW_CMD_PASSWORD_SET,
    IFW_CMD_PASSWORD_CLEAR,
    IFW_CMD_WCACHE_ON,
    IFW_CMD_WCACHE_OFF,
    IFW_CMD_LOOKAHEAD_ON,
    IFW_CMD_LOOKAHEAD_OFF,
    IFW_CMD_APM_ON,
    IFW_CMD_APM_OFF
  } ifw_cmd_t;

  typedef struct packed {
    logic smart_en;
    logic security_en;
    logic wcache_en;
    logic lookahead_en;
    logic apm_en;
    logic [15:0] rd_data;
    logic rd_valid;
    logic cmd_done;
    logic cmd_abort;
  } ifw_state_t;

endpackage

// *** test/ifw_feature_words_properties.sv ***
// Purpose: Port-level assertions for the identify feature word generator
// Assumes: Bound to every instance; fixed bits are the same whatever the build options
// Notes:   Option and live-enable bits are masked out of the fixed-bit checks
`timescale 1ns/1ps

module ifw_feature_words_properties
  import ifw_pkg::*;
(
  input wire logic CLK_IN,            // Clock
  input wire logic RESET_N_IN,        // Synchronous reset, active low
  input wire logic IDENT_RD_IN,       // Read strobe
  input wire logic [7:0] IDENT_IDX_IN, // Word index
  input wire logic [15:0] IDENT_DATA_OUT, // Read data
  input wire logic IDENT_VALID_OUT,   // Read data valid
  input wire logic CMD_VALID_IN,      // Command strobe
  input wire logic CMD_DONE_OUT,      // Command accepted
  input wire logic CMD_ABORT_OUT,     // Command refused
  input wire logic SMART_NV_OUT       // SMART enable state
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  a_read_answer: assert property (IDENT_RD_IN |=> IDENT_VALID_OUT)
    else $error("read not answered after one cycle");
  a_valid_quiet: assert property (!IDENT_RD_IN |=> !IDENT_VALID_OUT)
    else $error("read valid without a read");
  a_sup1_fixed: assert property (IDENT_RD_IN && IDENT_IDX_IN == 8'h52 |=> (IDENT_DATA_OUT & 16'hff9c) == 16'h7008)
    else $error("supported word one fixed bits wrong");
  a_sup2_fixed: assert property (IDENT_RD_IN && IDENT_IDX_IN == 8'h53 |-> ##1 (IDENT_DATA_OUT & 16'hfff7) == 16'h7404)
    else $error("supported word two fixed bits wrong");
  a_sup3_fixed: assert property (IDENT_RD_IN && IDENT_IDX_IN == 8'h54 |=> (IDENT_DATA_OUT & 16'hff9f) == 16'h4000)
    else $error("supported word three fixed bits wrong");
  a_en1_fixed: assert property (IDENT_RD_IN && IDENT_IDX_IN == 8'h55 |=> (IDENT_DATA_OUT & 16'hff9c) == 16'h7008)
    else $error("enabled word one fixed bits wrong");
  a_en2_fixed: assert property (IDENT_RD_IN && IDENT_IDX_IN == 8'h56 |-> ##1 (IDENT_DATA_OUT & 16'hfff7) == 16'hb404)
    else $error("enabled word two fixed bits wrong");
  a_en3_fixed: assert property (IDENT_RD_IN && IDENT_IDX_IN == 8'h57 |=> (IDENT_DATA_OUT & 16'hff9f) == 16'h4000)
    else $error("enabled word three fixed bits wrong");
  a_smart_mirror: assert property (IDENT_RD_IN && IDENT_IDX_IN == 8'h55 |=> IDENT_DATA_OUT[0] == $past(SMART_NV_OUT))
    else $error("SMART enable bit differs from stored state");
  a_cmd_answer: assert property (CMD_VALID_IN |=> CMD_DONE_OUT != CMD_ABORT_OUT)
    else $error("command not answered by exactly one pulse");
  a_cmd_quiet: assert property (!CMD_VALID_IN |=> $stable(SMART_NV_OUT) && !CMD_DONE_OUT && !CMD_ABORT_OUT)
    else $error("state or answer changed without a command");
endmodule

bind ifw_identify_feature_words ifw_feature_words_properties u_props (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .IDENT_RD_IN(IDENT_RD_IN), .IDENT_IDX_IN(IDENT_IDX_IN), .IDENT_DATA_OUT(IDENT_DATA_OUT),
  .IDENT_VALID_OUT(IDENT_VALID_OUT), .CMD_VALID_IN(CMD_VALID_IN), .CMD_DONE_OUT(CMD_DONE_OUT),
  .CMD_ABORT_OUT(CMD_ABORT_OUT), .SMART_NV_OUT(SMART_NV_OUT));

// *** test/ifw_host_model.sv ***
// Purpose: Host controller issuing identify reads and feature commands
// Assumes: One access per call, answer sampled at the falling edge after it
// Notes:   Index and command stay on the lines after the strobe drops
`timescale 1ns/1ps

module ifw_host_model
  import ifw_pkg::*;
(
  input wire logic clk_in,          // Clock
  input wire logic [15:0] data_in,  // Read data
  input wire logic valid_in,        // Read valid
  input wire logic done_in,         // Command accepted
  input wire logic abort_in,        // Command refused
  output logic rd_out,              // Read strobe
  output logic [7:0] idx_out,       // Word index
  output ifw_cmd_t cmd_out,         // Command code
  output logic cmd_valid_out        // Command strobe
);
  logic reported;

  initial begin
    rd_out = 1'b0;
    idx_out = 8'h00;
    cmd_out = IFW_CMD_NONE;
    cmd_valid_out = 1'b0;
    reported = 1'b0;
  end

  task automatic access(input logic rd, input logic [7:0] idx, input ifw_cmd_t cmd, input logic cv,
                        output logic [15:0] data, output logic valid, output logic done, output logic abort);
    @(posedge clk_in);
    rd_out <= rd;
    idx_out <= idx;
    cmd_out <= cmd;
    cmd_valid_out <= cv;
    @(posedge clk_in);
    rd_out <= 1'b0;
    cmd_valid_out <= 1'b0;
    @(negedge clk_in);
    data = data_in;
    valid = valid_in;
    done = done_in;
    abort = abort_in;
    // Words are passed on untouched, never used to steer the host
    reported = !(data_in === 16'h0000 || data_in === 16'hffff);
  endtask
endmodule

// *** test/ifw_identify_feature_words_tb.sv ***
// Purpose: Self-checking bench for the identify feature word generator
// Assumes: One instance with every option on, one with most options off
// Notes:   Reads taken with a command see the state before that command
`timescale 1ns/1ps

module ifw_identify_feature_words_tb
  import ifw_pkg::*;
();
  logic clk;
  logic reset_n;
  logic smart_nv;
  logic rd, cv, valid, valid2, hit, hit2, done, done2, abort, abort2, nv, nv2, v, dn, ab;
  logic [7:0] idx;
  ifw_cmd_t cmd;
  logic [15:0] data, data2, d;
  int failures;
  int total_checks;

  ifw_identify_feature_words DUT (.CLK_IN(clk), .RESET_N_IN(reset_n), .IDENT_RD_IN(rd), .IDENT_IDX_IN(idx),
    .IDENT_DATA_OUT(data), .IDENT_VALID_OUT(valid), .IDENT_HIT_OUT(hit), .CMD_IN(cmd), .CMD_VALID_IN(cv),
    .CMD_DONE_OUT(done), .CMD_ABORT_OUT(abort), .SMART_NV_IN(smart_nv), .SMART_NV_OUT(nv));
  ifw_identify_feature_words #(.SMART_SUPPORTED(1'b0), .SECURITY_SUPPORTED(1'b0), .WCACHE_SUPPORTED(1'b0),
    .APM_SUPPORTED(1'b0), .GPL_SUPPORTED(1'b0)) DUT_OFF (
    .CLK_IN(clk), .RESET_N_IN(reset_n), .IDENT_RD_IN(rd), .IDENT_IDX_IN(idx), .IDENT_DATA_OUT(data2),
    .IDENT_VALID_OUT(valid2), .IDENT_HIT_OUT(hit2), .CMD_IN(cmd), .CMD_VALID_IN(cv), .CMD_DONE_OUT(done2),
    .CMD_ABORT_OUT(abort2), .SMART_NV_IN(smart_nv), .SMART_NV_OUT(nv2));
  ifw_host_model host (.clk_in(clk), .data_in(data), .valid_in(valid), .done_in(done), .abort_in(abort),
    .rd_out(rd), .idx_out(idx), .cmd_out(cmd), .cmd_valid_out(cv));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic nv_val);
    @(posedge clk);
    reset_n <= 1'b0;
    smart_nv <= nv_val;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  task automatic t_idle_words();
    logic [15:0] on_w[8] = '{16'h0, 16'h706b, 16'h740c, 16'h4060, 16'h7068, 16'hb404, 16'h4060, 16'h0};
    logic [15:0] off_w[8] = '{16'h0, 16'h7048, 16'h7404, 16'h4040, 16'h7048, 16'hb404, 16'h4040, 16'h0};
    for (int i = 0; i < 8; i++) begin
      host.access(1'b1, 8'h51 + 8'(i), IFW_CMD_NONE, 1'b0, d, v, dn, ab);
      check(16'({v, valid2}), 16'h0003);
      check(16'(host.reported), (i > 0 && i < 7) ? 16'h0001 : 16'h0000);
      check(16'({hit, hit2}), (i > 0 && i < 7) ? 16'h0003 : 16'h0000);
      check(d, on_w[i]);
      check(data2, off_w[i]);
    end
  endtask

  task automatic t_commands();
    ifw_cmd_t c[11] = '{IFW_CMD_SMART_ON, IFW_CMD_PASSWORD_SET, IFW_CMD_WCACHE_OFF, IFW_CMD_LOOKAHEAD_OFF,
      IFW_CMD_APM_ON, IFW_CMD_NONE, IFW_CMD_APM_OFF, IFW_CMD_PASSWORD_CLEAR, IFW_CMD_SMART_OFF,
      IFW_CMD_WCACHE_ON, IFW_CMD_LOOKAHEAD_ON};
    logic [15:0] e85[12] = '{16'h7068, 16'h7069, 16'h706b, 16'h704b, 16'h700b, 16'h700b, 16'h700b,
      16'h700b, 16'h7009, 16'h7008, 16'h7028, 16'h7068};
    for (int i = 0; i < 11; i++) begin
      host.access(1'b1, IFW_IDX_ENABLED_1, c[i], 1'b1, d, v, dn, ab);
      check(d, e85[i]);
      check(16'({dn, ab}), (c[i] == IFW_CMD_NONE) ? 16'h0001 : 16'h0002);
      check(16'({done2, abort2}), (c[i] inside {IFW_CMD_NONE, IFW_CMD_SMART_ON, IFW_CMD_PASSWORD_SET,
        IFW_CMD_WCACHE_ON, IFW_CMD_APM_ON}) ? 16'h0001 : 16'h0002);
      host.access(1'b1, IFW_IDX_ENABLED_1, IFW_CMD_NONE, 1'b0, d, v, dn, ab);
      check(d, e85[i + 1]);
      check(data2, (i >= 3 && i < 10) ? 16'h7008 : 16'h7048);
      host.access(1'b1, IFW_IDX_ENABLED_2, IFW_CMD_NONE, 1'b0, d, v, dn, ab);
      check(d, (i == 4 || i == 5) ? 16'hb40c : 16'hb404);
      check(data2, 16'hb404);
    end
  endtask

  task automatic t_smart_persist();
    ifw_cmd_t c[3] = '{IFW_CMD_SMART_ON, IFW_CMD_PASSWORD_SET, IFW_CMD_APM_ON};
    for (int i = 0; i < 3; i++) begin
      host.access(1'b0, 8'h00, c[i], 1'b1, d, v, dn, ab);
      check(16'(v), 16'h0000);
    end
    check(16'({nv, nv2}), 16'h0002);
    do_reset(nv);
    host.access(1'b1, IFW_IDX_ENABLED_1, IFW_CMD_NONE, 1'b0, d, v, dn, ab);
    check(d, 16'h7069);
    check(data2, 16'h7048);
    host.access(1'b1, IFW_IDX_ENABLED_2, IFW_CMD_NONE, 1'b0, d, v, dn, ab);
    check(d, 16'hb404);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    failures = 0;
    total_checks = 0;
    reset_n = 1'b0;
    smart_nv = 1'b0;
    do_reset(1'b0);
    t_idle_words();
    t_commands();
    t_smart_persist();
    wrap_up();
  end

  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
